// ==== pkg/pot_cmd_defs.vh ====
`ifndef POT_CMD_DEFS_VH
`define POT_CMD_DEFS_VH

// instruction opcodes, upper nibble of the instruction byte
`define OP_LOAD_ALL     4'h1
`define OP_STEP         4'h2
`define OP_SAVE_ALL     4'h8
`define OP_READ_WIPER   4'h9
`define OP_WRITE_WIPER  4'ha
`define OP_READ_STORED  4'hb
`define OP_WRITE_STORED 4'hc
`define OP_LOAD_ONE     4'hd
`define OP_SAVE_ONE     4'he

// field positions in the address and instruction bytes
`define TYPE_MSB  7
`define TYPE_LSB  4
`define ADDR_MSB  3
`define ADDR_LSB  0
`define OPC_MSB   7
`define OPC_LSB   4
`define POT_MSB   3
`define POT_LSB   2
`define SLOT_MSB  1
`define SLOT_LSB  0

// wiper range and reset values
`define WIPER_MAX     6'h3f
`define WIPER_MIN     6'h00
`define WIPER_RST     6'h00
`define STORED_RST    6'h00
`define LAST_POT      2'h3

// programming time of a stored setting
`define PROG_TIME_MS  5
`define CORE_CLK_KHZ  50000
`define PROG_CYCLES   (`PROG_TIME_MS * `CORE_CLK_KHZ)

`endif

// ==== verilog/sync2.v ====
`timescale 1ns/1ps
module sync2 #(
   parameter W = 1
) (
   // clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // asynchronous in, synchronised out
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta_r;

   // meta_r feeds nothing but q
   always @(posedge clk) begin
      if (!rst_n) begin
         meta_r <= {W{1'b0}};
         q      <= {W{1'b0}};
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // sync2

// ==== verilog/stored_setting_mem.v ====
`timescale 1ns/1ps
`include "pot_cmd_defs.vh"
module stored_setting_mem #(
   parameter DW = 6,
   parameter AW = 4
) (
   // clock and reset
   input  wire          clk,
   input  wire          rst_n,
   // write port
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [DW-1:0] wdata,
   // registered read port
   input  wire [AW-1:0] raddr,
   output reg  [DW-1:0] rdata
);
   localparam N = 1 << AW;

   wire [N*DW-1:0] flat;

   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_entry
         reg [DW-1:0] cell_r;
         always @(posedge clk) begin
            if (!rst_n) begin
               cell_r <= `STORED_RST;
            end else if (we && (waddr == i)) begin
               cell_r <= wdata;
            end
         end
         assign flat[i*DW +: DW] = cell_r;
      end
   endgenerate

   always @(posedge clk) begin
      if (!rst_n) begin
         rdata <= {DW{1'b0}};
      end else begin
         rdata <= flat[raddr*DW +: DW];
      end
   end
endmodule // stored_setting_mem

// ==== verilog/quad_pot_command_decoder.v ====
// Behaviour
// - global load copies chosen stored slot into every pot's wiper.
// - global save writes every pot's wiper into its chosen stored slot.
// - after step command ack, master steps wiper per SCL until STOP.
// - step pulse with SDA high moves wiper one segment up.
// - step pulse with SDA low moves wiper one segment down.
// - opcode 1001 returns selected wiper as one byte, MSB first.
// - opcode 1010 loads the following data byte into selected wiper.
// - opcode 1011 returns the chosen stored setting as one byte.
// - opcode 1100 stores the following data byte in chosen slot.
// - opcode 0001, pot bits zero, is the global load; acked.
// - opcode 1000, pot bits zero, is the global save; no data.
// - opcode 1110 copies the selected wiper into the chosen slot.
// - opcode 1101 loads the selected wiper from the chosen slot.
// - address byte must match device type nibble and strap pins.
// - opcode 0010, slot bits zero, enters step mode.
// - stored setting programming starts only after STOP.
`timescale 1ns/1ps
`include "pot_cmd_defs.vh"
module quad_pot_command_decoder #(
   // device type nibble; value is arbitrary
   parameter [3:0] DEV_TYPE    = 4'ha,
   parameter       PROG_CYCLES = `PROG_CYCLES,
   parameter       PROG_W      = 18
) (
   // clock and reset
   input  wire        core_clk,
   input  wire        rst_n,
   // serial bus pins, sda is open drain
   input  wire        scl,
   input  wire        sdaIn,
   output reg         sdaOut,
   output reg         sdaOe,
   // strapped address pins
   input  wire [3:0]  strapAddr,
   // decoded wiper positions, pot n at [6n+5:6n]
   output reg  [23:0] wiperPos,
   // stored setting programming in progress
   output reg         nvBusy
);
   localparam ST_IDLE   = 4'h0;
   localparam ST_ADDR   = 4'h1;
   localparam ST_AACK   = 4'h2;
   localparam ST_INSTR  = 4'h3;
   localparam ST_IACK   = 4'h4;
   localparam ST_WDATA  = 4'h5;
   localparam ST_DACK   = 4'h6;
   localparam ST_RDATA  = 4'h7;
   localparam ST_RACK   = 4'h8;
   localparam ST_STEP   = 4'h9;
   localparam ST_IGNORE = 4'ha;

   localparam SQ_IDLE = 3'h0;
   localparam SQ_RD   = 3'h1;
   localparam SQ_WT   = 3'h2;
   localparam SQ_CAP  = 3'h3;
   localparam SQ_WR   = 3'h4;
   localparam SQ_PROG = 3'h5;

   localparam JOB_NONE  = 2'h0;
   localparam JOB_LOAD  = 2'h1;
   localparam JOB_SAVE  = 2'h2;
   localparam JOB_WRITE = 2'h3;

   // cut on purpose: the last count must fit PROG_W bits
   localparam integer      PROG_LAST_I = PROG_CYCLES - 1;
   localparam [PROG_W-1:0] PROG_LAST   = PROG_LAST_I[PROG_W-1:0];

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and bus conditions
   wire       sclS;
   wire       sdaS;
   wire [3:0] strapS;
   reg        sclD_r;
   reg        sdaD_r;

   sync2 #(.W(6)) u_sync (
      .clk   (core_clk),
      .rst_n (rst_n),
      .d     ({scl, sdaIn, strapAddr}),
      .q     ({sclS, sdaS, strapS})
   );

   always @(posedge core_clk) begin
      if (!rst_n) begin
         sclD_r <= 1'b1;
         sdaD_r <= 1'b1;
      end else begin
         sclD_r <= sclS;
         sdaD_r <= sdaS;
      end
   end

   wire sclRise   = sclS & ~sclD_r;
   wire sclFall   = ~sclS & sclD_r;
   wire startDet  = sclS & sclD_r & sdaD_r & ~sdaS;
   wire stopDet   = sclS & sclD_r & ~sdaD_r & sdaS;

   ////////////////////////////////////////////////////////////////////////
   // state
   reg [3:0]        state_r;
   reg [2:0]        bitCnt_r;
   reg              byteDone_r;
   reg [7:0]        shift_r;
   reg [7:0]        txByte_r;
   reg [3:0]        opcode_r;
   reg [1:0]        pot_r;
   reg [1:0]        slot_r;
   reg [1:0]        job_r;
   reg              jobAll_r;
   reg [5:0]        data_r;
   reg [2:0]        seq_r;
   reg [1:0]        seqJob_r;
   reg              seqAll_r;
   reg [1:0]        seqPot_r;
   reg [1:0]        seqSlot_r;
   reg [5:0]        seqData_r;
   reg [PROG_W-1:0] progCnt_r;
   reg [3:0]        memRdAddr_r;
   wire [5:0]       memRd;

   ////////////////////////////////////////////////////////////////////////
   // decode helpers
   wire [3:0] rxOpc  = shift_r[`OPC_MSB:`OPC_LSB];
   wire [1:0] rxPot  = shift_r[`POT_MSB:`POT_LSB];
   wire [1:0] rxSlot = shift_r[`SLOT_MSB:`SLOT_LSB];
   wire       busy   = (seq_r != SQ_IDLE);

   wire addrOk = (shift_r[`TYPE_MSB:`TYPE_LSB] == DEV_TYPE) &&
                 (shift_r[`ADDR_MSB:`ADDR_LSB] == strapS) && !busy;

   reg instrOk;
   always @* begin
      instrOk = 1'b0;
      case (rxOpc)
         `OP_READ_WIPER:   instrOk = (rxSlot == 2'h0);
         `OP_WRITE_WIPER:  instrOk = (rxSlot == 2'h0);
         `OP_STEP:         instrOk = (rxSlot == 2'h0);
         `OP_LOAD_ALL:     instrOk = (rxPot == 2'h0);
         `OP_SAVE_ALL:     instrOk = (rxPot == 2'h0);
         `OP_READ_STORED:  instrOk = 1'b1;
         `OP_WRITE_STORED: instrOk = 1'b1;
         `OP_LOAD_ONE:     instrOk = 1'b1;
         `OP_SAVE_ONE:     instrOk = 1'b1;
         default:          instrOk = 1'b0;
      endcase
   end

   wire [5:0] wiperSel = wiperPos[pot_r*6 +: 6];
   wire [5:0] seqWiper = wiperPos[seqPot_r*6 +: 6];
   wire [7:0] rdByte   = (opcode_r == `OP_READ_WIPER) ?
                         {2'h0, wiperSel} : {2'h0, memRd};
   wire       seqLast  = !seqAll_r || (seqPot_r == `LAST_POT);

   ////////////////////////////////////////////////////////////////////////
   // stored settings, written only by the post-STOP sequencer
   wire       memWe    = (seq_r == SQ_WR);
   wire [5:0] memWData = (seqJob_r == JOB_WRITE) ? seqData_r : seqWiper;
   wire [3:0] memRAddr = busy ? {seqPot_r, seqSlot_r} : memRdAddr_r;

   stored_setting_mem #(.DW(6), .AW(4)) u_mem (
      .clk   (core_clk),
      .rst_n (rst_n),
      .we    (memWe),
      .waddr ({seqPot_r, seqSlot_r}),
      .wdata (memWData),
      .raddr (memRAddr),
      .rdata (memRd)
   );

   ////////////////////////////////////////////////////////////////////////
   // command engine and post-STOP sequencer share the wiper registers
   always @(posedge core_clk) begin
      if (!rst_n) begin
         state_r     <= ST_IDLE;
         bitCnt_r    <= 3'h0;
         byteDone_r  <= 1'b0;
         shift_r     <= 8'h00;
         txByte_r    <= 8'h00;
         opcode_r    <= 4'h0;
         pot_r       <= 2'h0;
         slot_r      <= 2'h0;
         job_r       <= JOB_NONE;
         jobAll_r    <= 1'b0;
         data_r      <= 6'h00;
         seq_r       <= SQ_IDLE;
         seqJob_r    <= JOB_NONE;
         seqAll_r    <= 1'b0;
         seqPot_r    <= 2'h0;
         seqSlot_r   <= 2'h0;
         seqData_r   <= 6'h00;
         progCnt_r   <= {PROG_W{1'b0}};
         memRdAddr_r <= 4'h0;
         sdaOut      <= 1'b0;
         sdaOe       <= 1'b0;
         wiperPos    <= {4{`WIPER_RST}};
         nvBusy      <= 1'b0;
      end else begin
         // open drain: only ever pulls low
         sdaOut <= 1'b0;
         if (startDet) begin
            // a repeated start drops whatever was pending
            state_r    <= ST_ADDR;
            bitCnt_r   <= 3'h0;
            byteDone_r <= 1'b0;
            sdaOe      <= 1'b0;
            job_r      <= JOB_NONE;
         end else if (stopDet) begin
            state_r <= ST_IDLE;
            sdaOe   <= 1'b0;
            job_r   <= JOB_NONE;
            if (job_r != JOB_NONE) begin
               seq_r     <= (job_r == JOB_LOAD) ? SQ_RD : SQ_WR;
               seqJob_r  <= job_r;
               seqAll_r  <= jobAll_r;
               seqPot_r  <= jobAll_r ? 2'h0 : pot_r;
               seqSlot_r <= slot_r;
               seqData_r <= data_r;
            end
         end else begin
            case (state_r)
               ST_ADDR, ST_INSTR, ST_WDATA: begin
                  if (sclRise) begin
                     shift_r    <= {shift_r[6:0], sdaS};
                     bitCnt_r   <= bitCnt_r + 3'h1;
                     byteDone_r <= (bitCnt_r == 3'h7);
                  end else if (sclFall && byteDone_r) begin
                     byteDone_r <= 1'b0;
                     if (state_r == ST_ADDR) begin
                        sdaOe   <= addrOk;
                        state_r <= addrOk ? ST_AACK : ST_IGNORE;
                     end else if (state_r == ST_INSTR) begin
                        sdaOe   <= instrOk;
                        state_r <= instrOk ? ST_IACK : ST_IGNORE;
                        opcode_r    <= rxOpc;
                        pot_r       <= rxPot;
                        slot_r      <= rxSlot;
                        memRdAddr_r <= {rxPot, rxSlot};
                     end else begin
                        sdaOe   <= 1'b1;
                        state_r <= ST_DACK;
                        if (opcode_r == `OP_WRITE_WIPER) begin
                           wiperPos[pot_r*6 +: 6] <= shift_r[5:0];
                        end else begin
                           job_r    <= JOB_WRITE;
                           jobAll_r <= 1'b0;
                           data_r   <= shift_r[5:0];
                        end
                     end
                  end
               end
               ST_AACK: begin
                  if (sclFall) begin
                     sdaOe    <= 1'b0;
                     state_r  <= ST_INSTR;
                     bitCnt_r <= 3'h0;
                  end
               end
               ST_IACK: begin
                  if (sclFall) begin
                     sdaOe    <= 1'b0;
                     bitCnt_r <= 3'h0;
                     state_r  <= ST_IGNORE;
                     case (opcode_r)
                        `OP_READ_WIPER, `OP_READ_STORED: begin
                           txByte_r <= rdByte;
                           sdaOe    <= ~rdByte[7];
                           state_r  <= ST_RDATA;
                        end
                        `OP_WRITE_WIPER, `OP_WRITE_STORED: begin
                           state_r  <= ST_WDATA;
                        end
                        `OP_STEP: begin
                           state_r  <= ST_STEP;
                        end
                        `OP_LOAD_ONE, `OP_LOAD_ALL: begin
                           job_r    <= JOB_LOAD;
                           jobAll_r <= (opcode_r == `OP_LOAD_ALL);
                        end
                        `OP_SAVE_ONE, `OP_SAVE_ALL: begin
                           job_r    <= JOB_SAVE;
                           jobAll_r <= (opcode_r == `OP_SAVE_ALL);
                        end
                        default: begin
                           state_r  <= ST_IGNORE;
                        end
                     endcase
                  end
               end
               ST_DACK: begin
                  if (sclFall) begin
                     sdaOe   <= 1'b0;
                     state_r <= ST_IGNORE;
                  end
               end
               ST_RDATA: begin
                  if (sclRise) begin
                     bitCnt_r   <= bitCnt_r + 3'h1;
                     byteDone_r <= (bitCnt_r == 3'h7);
                  end else if (sclFall) begin
                     if (byteDone_r) begin
                        byteDone_r <= 1'b0;
                        sdaOe      <= 1'b0;
                        state_r    <= ST_RACK;
                     end else begin
                        txByte_r <= {txByte_r[6:0], 1'b0};
                        sdaOe    <= ~txByte_r[6];
                     end
                  end
               end
               ST_RACK: begin
                  // single byte only; master ack or nack both end it
                  if (sclFall) begin
                     state_r <= ST_IGNORE;
                  end
               end
               ST_STEP: begin
                  if (sclRise) begin
                     if (sdaS) begin
                        if (wiperSel != `WIPER_MAX) begin
                           wiperPos[pot_r*6 +: 6] <= wiperSel + 6'h01;
                        end
                     end else begin
                        if (wiperSel != `WIPER_MIN) begin
                           wiperPos[pot_r*6 +: 6] <= wiperSel - 6'h01;
                        end
                     end
                  end
               end
               ST_IDLE, ST_IGNORE: begin
                  sdaOe <= 1'b0;
               end
               default: begin
                  state_r <= ST_IDLE;
                  sdaOe   <= 1'b0;
               end
            endcase
         end

         // post-STOP sequencer; registered read needs one wait cycle
         case (seq_r)
            SQ_IDLE: begin
               nvBusy <= 1'b0;
            end
            SQ_RD: begin
               seq_r <= SQ_WT;
            end
            SQ_WT: begin
               seq_r <= SQ_CAP;
            end
            SQ_CAP: begin
               wiperPos[seqPot_r*6 +: 6] <= memRd;
               seqPot_r <= seqPot_r + 2'h1;
               seq_r    <= seqLast ? SQ_IDLE : SQ_RD;
            end
            SQ_WR: begin
               seqPot_r <= seqPot_r + 2'h1;
               if (seqLast) begin
                  seq_r     <= SQ_PROG;
                  nvBusy    <= 1'b1;
                  progCnt_r <= {PROG_W{1'b0}};
               end
            end
            SQ_PROG: begin
               // address is nacked meanwhile, so stale reads are avoided
               if (progCnt_r == PROG_LAST) begin
                  seq_r  <= SQ_IDLE;
                  nvBusy <= 1'b0;
               end else begin
                  progCnt_r <= progCnt_r + {{(PROG_W-1){1'b0}}, 1'b1};
               end
            end
            default: begin
               seq_r <= SQ_IDLE;
            end
         endcase
      end
   end
endmodule // quad_pot_command_decoder

// ==== verification/bus_master_model.sv ====
`timescale 1ns/1ps
module bus_master_model (
   // bus clock and data drive, drive high means released
   output logic scl,
   output logic sdaDrive,
   // wired data level seen on the bus
   input  wire  sdaLine
);
   // idle bus: clock stands still high, data released to the pull-up
   initial begin
      scl      = 1'b1;
      sdaDrive = 1'b1;
   end
   //////////////////////////////
   // data moves mid low phase so the slave never sees a false start or stop
   task bitOut(input logic b);
      #40 sdaDrive = b;
      #40 scl = 1'b1;
      #80 scl = 1'b0;
   endtask
   task bitIn(output logic b);
      #40 sdaDrive = 1'b1;
      #40 b = sdaLine;
      scl = 1'b1;
      #80 scl = 1'b0;
   endtask
   task start;
      #80 sdaDrive = 1'b0;
      #80 scl = 1'b0;
   endtask
   task stop;
      #40 sdaDrive = 1'b0;
      #40 scl = 1'b1;
      #80 sdaDrive = 1'b1;
      #80;
   endtask
   task wrByte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bitOut(v[i]);
      bitIn(s);
      ack = !s;
   endtask
   task rdByte(output logic [7:0] v);
      for (int i = 7; i >= 0; i--) bitIn(v[i]);
      bitOut(1'b1);
   endtask
   // every rising clock steps, so step mode is left with one upward pulse
   // and a start then stop while the clock is still high
   task endStep;
      #40 sdaDrive = 1'b1;
      #40 scl = 1'b1;
      #80 sdaDrive = 1'b0;
      #80 sdaDrive = 1'b1;
      #80;
   endtask
endmodule // bus_master_model

// ==== verification/pot_cmd_monitor.sv ====
`timescale 1ns/1ps
module pot_cmd_monitor #(
   parameter PROG_CYCLES = 20
) (
   // clock and reset
   input wire        core_clk,
   input wire        rst_n,
   // bus pins
   input wire        scl,
   input wire        sdaIn,
   input wire        sdaOut,
   input wire        sdaOe,
   // straps and outputs
   input wire [3:0]  strapAddr,
   input wire [23:0] wiperPos,
   input wire        nvBusy
);
   reg        sclPrev_r;
   reg        sdaPrev_r;
   reg        sdaMoved_r;
   reg [7:0]  stopAgo_r;
   reg [31:0] busyLen_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // a step moves a pot by one and never wraps past an end
   function automatic bit unitMove(input [23:0] n, input [23:0] o);
      unitMove = 1'b1;
      for (int p = 0; p < 4; p++)
         if (!(n[6*p+:6] == o[6*p+:6] ||
              (n[6*p+:6] == o[6*p+:6] + 6'h01 && o[6*p+:6] != 6'h3f) ||
              (n[6*p+:6] == o[6*p+:6] - 6'h01 && o[6*p+:6] != 6'h00)))
            unitMove = 1'b0;
   endfunction
   //////////////////////////////
   // sdaMoved_r excludes start/stop pulses, where copies may land
   always @(posedge core_clk) begin
      sclPrev_r <= scl;
      sdaPrev_r <= sdaIn;
      if (!rst_n) begin
         sdaMoved_r <= 1'b1;
         stopAgo_r  <= 8'hff;
         busyLen_r  <= 32'h0;
      end else begin
         if (!scl)
            sdaMoved_r <= 1'b0;
         else if (sdaIn != sdaPrev_r)
            sdaMoved_r <= 1'b1;
         if (scl && sclPrev_r && sdaIn && !sdaPrev_r)
            stopAgo_r <= 8'h00;
         else if (stopAgo_r != 8'hff)
            stopAgo_r <= stopAgo_r + 8'h01;
         busyLen_r <= nvBusy ? busyLen_r + 32'h1 : 32'h0;
      end
   end
   //////////////////////////////
   od_low_a: assert property (sdaOut == 1'b0)
      else $error("sda value not low");
   ack_launch_a: assert property ($rose(sdaOe) |-> !scl)
      else $error("sda drive began with clock high");
   ack_hold_a: assert property (scl && $past(scl) |-> $stable(sdaOe))
      else $error("sda drive changed with clock high");
   prog_after_stop_a: assert property ($rose(nvBusy) |-> stopAgo_r < 8'd24)
      else $error("programming began without a stop");
   prog_length_a: assert property ($fell(nvBusy) |->
      busyLen_r >= PROG_CYCLES - 1 && busyLen_r <= PROG_CYCLES + 1)
      else $error("programming time wrong");
   busy_quiet_a: assert property (nvBusy |-> !sdaOe)
      else $error("bus answered while programming");
   busy_frozen_a: assert property (nvBusy && $past(nvBusy) |-> $stable(wiperPos))
      else $error("wiper moved while programming");
   step_unit_a: assert property (scl && !sdaMoved_r |->
      unitMove(wiperPos, $past(wiperPos)))
      else $error("step not one segment or wrapped");
endmodule // pot_cmd_monitor
bind quad_pot_command_decoder pot_cmd_monitor #(.PROG_CYCLES(PROG_CYCLES)) i_mon (
   .core_clk(core_clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaIn),
   .sdaOut(sdaOut), .sdaOe(sdaOe), .strapAddr(strapAddr),
   .wiperPos(wiperPos), .nvBusy(nvBusy));

// ==== verification/quad_pot_command_decoder_test.sv ====
`timescale 1ns/1ps
module quad_pot_command_decoder_test;
   localparam [3:0] TYPE_ID = 4'h6; // arbitrary type nibble
   localparam [3:0] STRAP   = 4'h9;
   localparam [7:0] ADR     = {TYPE_ID, STRAP};
   localparam [1:0] M_CTL = 2'd0, M_WR = 2'd1, M_RD = 2'd2, M_STEP = 2'd3;
   reg          core_clk;
   reg          rst_n;
   reg  [3:0]   strapAddr;
   wire         scl;
   wire         sdaDrive;
   wire         sdaIn;
   wire         sdaOut;
   wire         sdaOe;
   wire         nvBusy;
   wire [23:0]  wiperPos;
   logic [23:0] expPos;
   logic [2:0]  acks;
   logic [7:0]  rd;
   integer      mismatches;
   integer      checksDone;
   // open drain with pull-up: any party pulling low wins
   assign sdaIn = sdaDrive & ~sdaOe;
   always #10 core_clk = ~core_clk;
   quad_pot_command_decoder #(.DEV_TYPE(TYPE_ID), .PROG_CYCLES(20)) i_dut (
      .core_clk(core_clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaIn),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .strapAddr(strapAddr),
      .wiperPos(wiperPos), .nvBusy(nvBusy));
   bus_master_model i_master (.scl(scl), .sdaDrive(sdaDrive), .sdaLine(sdaIn));
   //////////////////////////////
   task finish_test;
      if (mismatches == 0 && checksDone > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input [23:0] e, input [23:0] g);
      checksDone++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // device refuses the bus while programming, so wait it out
   task waitIdle;
      repeat (12) @(negedge core_clk);
      for (int i = 0; i < 200 && nvBusy !== 1'b0; i++) @(negedge core_clk);
      if (nvBusy !== 1'b0) begin
         mismatches++;
         $display("CHECK FAILED nvBusy expected 0 seen %b", nvBusy);
         finish_test;
      end
   endtask
   task xfer(input [7:0] a, input [7:0] ins, input [1:0] m, input [7:0] wd);
      acks = 3'b000;
      rd = 8'h00;
      i_master.start;
      i_master.wrByte(a, acks[2]);
      if (acks[2]) i_master.wrByte(ins, acks[1]);
      if (acks[1] && m == M_WR) i_master.wrByte(wd, acks[0]);
      if (acks[1] && m == M_RD) i_master.rdByte(rd);
      if (m != M_STEP) begin
         i_master.stop;
         waitIdle;
      end
   endtask
   task wrWiper(input [1:0] p, input [7:0] v);
      xfer(ADR, {4'ha, p, 2'b00}, M_WR, v);
      chk("write acks", 3'b111, acks);
      expPos[6*p+:6] = v[5:0];
   endtask
   task stepSeq(input [7:0] pat, input int n);
      for (int i = 0; i < n; i++) i_master.bitOut(pat[i]);
      i_master.endStep;
      waitIdle;
   endtask
   //////////////////////////////
   initial begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      strapAddr = STRAP;
      mismatches = 0;
      checksDone = 0;
      expPos = 24'h0;
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      chk("wiperPos", expPos, wiperPos);
      chk("nvBusy", 1'b0, nvBusy);
      wrWiper(2'd1, 8'h2a);
      chk("wiperPos", expPos, wiperPos);
      xfer(ADR, {4'h9, 2'd1, 2'b00}, M_RD, 8'h00);
      chk("read acks", 3'b110, acks);
      chk("read byte", 8'h2a, rd);
      // refusals: wrong strap, wrong type, bad opcode, bad slot bits
      xfer(ADR ^ 8'h01, {4'ha, 2'd1, 2'b00}, M_WR, 8'h11);
      chk("acks", 3'b000, acks);
      xfer(ADR ^ 8'h10, {4'ha, 2'd1, 2'b00}, M_WR, 8'h11);
      chk("acks", 3'b000, acks);
      xfer(ADR, 8'h34, M_WR, 8'h11);
      chk("acks", 3'b100, acks);
      xfer(ADR, {4'ha, 2'd1, 2'b01}, M_WR, 8'h11);
      chk("acks", 3'b100, acks);
      // the straps, not a fixed value, decide which address is taken
      strapAddr = 4'h3;
      repeat (4) @(negedge core_clk);
      xfer({TYPE_ID, 4'h3}, {4'ha, 2'd1, 2'b00}, M_WR, 8'h2a);
      chk("acks", 3'b111, acks);
      xfer(ADR, {4'ha, 2'd1, 2'b00}, M_WR, 8'h11);
      chk("acks", 3'b000, acks);
      strapAddr = STRAP;
      repeat (4) @(negedge core_clk);
      chk("wiperPos", expPos, wiperPos);
      xfer(ADR, {4'hc, 2'd1, 2'd2}, M_WR, 8'h15);
      chk("acks", 3'b111, acks);
      xfer(ADR, {4'hb, 2'd1, 2'd2}, M_RD, 8'h00);
      chk("stored byte", 8'h15, rd);
      for (int p = 0; p < 4; p++) wrWiper(p[1:0], 8'h30 | p[7:0]);
      xfer(ADR, {4'h8, 2'b00, 2'd3}, M_CTL, 8'h00);
      chk("acks", 3'b110, acks);
      for (int p = 0; p < 4; p++) wrWiper(p[1:0], 8'h00);
      xfer(ADR, {4'h1, 2'b00, 2'd3}, M_CTL, 8'h00);
      chk("acks", 3'b110, acks);
      expPos = {6'h33, 6'h32, 6'h31, 6'h30};
      chk("wiperPos", expPos, wiperPos);
      wrWiper(2'd2, 8'h05);
      xfer(ADR, {4'he, 2'd2, 2'd0}, M_CTL, 8'h00);
      xfer(ADR, {4'hd, 2'd2, 2'd3}, M_CTL, 8'h00);
      expPos[17:12] = 6'h32;
      chk("wiperPos", expPos, wiperPos);
      xfer(ADR, {4'hd, 2'd2, 2'd0}, M_CTL, 8'h00);
      expPos[17:12] = 6'h05;
      chk("wiperPos", expPos, wiperPos);
      // step at the top end: up, up, down, down, closing up
      wrWiper(2'd3, 8'h3e);
      xfer(ADR, {4'h2, 2'd3, 2'b00}, M_STEP, 8'h00);
      chk("acks", 3'b110, acks);
      stepSeq(8'h03, 4);
      expPos[23:18] = 6'h3e;
      chk("wiperPos", expPos, wiperPos);
      // step at the bottom end: three downs, closing up
      wrWiper(2'd0, 8'h01);
      xfer(ADR, {4'h2, 2'd0, 2'b00}, M_STEP, 8'h00);
      stepSeq(8'h00, 3);
      expPos[5:0] = 6'h01;
      chk("wiperPos", expPos, wiperPos);
      // mid-run reset on an idle bus clears wipers and stored settings
      rst_n = 1'b0;
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      expPos = 24'h0;
      chk("wiperPos", expPos, wiperPos);
      chk("nvBusy", 1'b0, nvBusy);
      xfer(ADR, {4'hb, 2'd1, 2'd2}, M_RD, 8'h00);
      chk("read acks", 3'b110, acks);
      chk("stored byte", 8'h00, rd);
      finish_test;
   end
endmodule // quad_pot_command_decoder_test
